// ### rtl/rtdc_counter.sv
// root thread debug counter: state registers, counter and register port
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module rtdc_counter #(
    parameter bit SAVE_RESTORE = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire rtdc_pkg::rtdc_bus_t bus,
    input wire rtdc_pkg::rtdc_evt_t evt,
    output logic [rtdc_pkg::DATA_W-1:0] rd_data,
    output logic [rtdc_pkg::CNT_W-1:0] dbg_count,
    output logic thread_pulse,
    output logic [rtdc_pkg::CNT_W-1:0] thread_count
);
    import rtdc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state

    logic [1:0] sel_reg;
    logic [2:0] mode_reg;
    logic [TAG_W-1:0] tag_reg;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    rtdc_arm_t arm_reg;
    rtdc_arm_t arm_next;
    logic [DATA_W-1:0] rd_data_reg;
    logic [DATA_W-1:0] rd_data_next;
    logic thread_pulse_reg;
    logic [CNT_W-1:0] thread_count_reg;

    ////////////////////////////////////////////////////////////////////////
    // address decode

    wire wr_ctrl = bus.wr && (bus.addr == OFF_CTRL);
    wire wr_tag = bus.wr && (bus.addr == OFF_TAG);
    // restore only exists where the counter travels with the context
    wire wr_count = SAVE_RESTORE && bus.wr && (bus.addr == OFF_COUNT);
    wire [1:0] wsel = bus.wdata[CTRL_SEL_LSB +: CTRL_SEL_W];
    wire [2:0] wmode = bus.wdata[CTRL_MODE_LSB +: CTRL_MODE_W];
    // extended state in transform modes with select once loads the counter at the change
    wire xf_load = wr_ctrl && rtdc_is_xform(wmode) && (wsel == SEL_ONCE);
    wire [CNT_W-1:0] tag_low = tag_reg[CNT_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // counter datapath

    logic [CNT_W-1:0] ev_next;
    logic ev_loaded;
    logic ev_thread;

    rtdc_next u_next (
        .sel(sel_reg),
        .mode(mode_reg),
        .arm(arm_reg),
        .evt(evt),
        .count(count_reg),
        .count_next(ev_next),
        .loaded(ev_loaded),
        .thread_event(ev_thread)
    );

    // a software restore beats an extended state load, which beats work
    always_comb begin
        if (wr_count) begin
            count_next = bus.wdata[CNT_W-1:0];
        end else if (xf_load) begin
            count_next = tag_low;
        end else begin
            count_next = ev_next;
        end
    end

    // load arming across pipeline state changes
    always_comb begin
        arm_next = arm_reg;
        if (wr_ctrl) begin
            if (wsel != SEL_ONCE) begin
                arm_next = ARM_IDLE;
            end else if (rtdc_is_xform(wmode)) begin
                arm_next = ARM_RUN;
            end else begin
                arm_next = ARM_WAIT;
            end
        end else begin
            case (arm_reg)
                ARM_WAIT: begin
                    if (ev_loaded) begin
                        arm_next = ARM_RUN;
                    end
                end
                ARM_RUN: begin
                    arm_next = ARM_RUN;
                end
                default: begin
                    arm_next = ARM_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux

    always_comb begin
        rd_data_next = RD_ZERO;
        if (!bus.rd) begin
            rd_data_next = RD_ZERO;
        end else if (bus.addr == OFF_CTRL) begin
            rd_data_next[CTRL_SEL_LSB +: CTRL_SEL_W] = sel_reg;
            rd_data_next[CTRL_MODE_LSB +: CTRL_MODE_W] = mode_reg;
        end else if (bus.addr == OFF_TAG) begin
            rd_data_next = tag_reg;
        end else if (bus.addr == OFF_COUNT) begin
            rd_data_next[CNT_W-1:0] = count_reg;
        end else if (bus.addr == OFF_STATUS) begin
            rd_data_next[2:0] = arm_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_reg <= RST_SEL;
            mode_reg <= RST_MODE;
            tag_reg <= RST_TAG;
        end else begin
            if (wr_ctrl) begin
                sel_reg <= wsel;
                mode_reg <= wmode;
            end
            if (wr_tag) begin
                tag_reg <= bus.wdata;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= RST_COUNT;
            arm_reg <= ARM_IDLE;
        end else begin
            count_reg <= count_next;
            arm_reg <= arm_next;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_reg <= RD_ZERO;
            thread_pulse_reg <= 1'b0;
            thread_count_reg <= RST_COUNT;
        end else begin
            rd_data_reg <= rd_data_next;
            thread_pulse_reg <= ev_thread;
            thread_count_reg <= count_next;
        end
    end

    assign rd_data = rd_data_reg;
    assign dbg_count = count_reg;
    assign thread_pulse = thread_pulse_reg;
    assign thread_count = thread_count_reg;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    wire sw_touch = wr_ctrl || wr_count;
    wire gen_mode = rtdc_is_general(mode_reg);
    wire dec_mode = rtdc_is_decode(mode_reg);
    wire xf_mode = rtdc_is_xform(mode_reg);

    logic rst_seen_reg;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_seen_reg <= 1'b0;
        end else begin
            rst_seen_reg <= 1'b1;
        end
    end

    property p_reset_zero;
        !rst_seen_reg |-> (count_reg == RST_COUNT) && !thread_pulse_reg;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("counter not zero after reset");

    property p_thread_pulse;
        ((gen_mode || xf_mode) && evt.cmd_valid) || (dec_mode && evt.mb_valid) |=> thread_pulse_reg;
    endproperty
    a_thread_pulse: assert property (p_thread_pulse) else $error("root thread not signalled");

    property p_free_cmd;
        (gen_mode || xf_mode) && sel_reg == SEL_FREE && evt.cmd_valid && !sw_touch
            |=> count_reg == CNT_W'($past(count_reg) + 24'h000001);
    endproperty
    a_free_cmd: assert property (p_free_cmd) else $error("free count missed command");

    property p_free_mb;
        dec_mode && sel_reg == SEL_FREE && evt.mb_valid && !sw_touch
            |=> count_reg == CNT_W'($past(count_reg) + 24'h000001);
    endproperty
    a_free_mb: assert property (p_free_mb) else $error("free count missed macroblock");

    property p_frozen;
        sel_reg == SEL_FROZEN && !sw_touch ##1 sel_reg == SEL_FROZEN && !sw_touch
            |=> $stable(count_reg);
    endproperty
    a_frozen: assert property (p_frozen) else $error("frozen counter moved");

    property p_once_gen;
        gen_mode && sel_reg == SEL_ONCE && arm_reg == ARM_WAIT && evt.cmd_valid && !sw_touch
            |=> count_reg == $past(evt.tag[CNT_W-1:0]) && arm_reg == ARM_RUN;
    endproperty
    a_once_gen: assert property (p_once_gen) else $error("first command tag not loaded");

    property p_once_dec;
        dec_mode && sel_reg == SEL_ONCE && arm_reg == ARM_WAIT && evt.mb_valid && evt.mb_first && !sw_touch
            |=> count_reg == $past(evt.tag[CNT_W-1:0]) && arm_reg == ARM_RUN;
    endproperty
    a_once_dec: assert property (p_once_dec) else $error("first slice tag not loaded");

    property p_wait_dec;
        dec_mode && arm_reg == ARM_WAIT && !evt.mb_first && !sw_touch |=> $stable(count_reg);
    endproperty
    a_wait_dec: assert property (p_wait_dec) else $error("counter moved before first slice");

    property p_always;
        gen_mode && sel_reg == SEL_ALWAYS && evt.cmd_valid && !sw_touch
            |=> count_reg == $past(evt.tag[CNT_W-1:0]);
    endproperty
    a_always: assert property (p_always) else $error("command tag not reloaded");

    property p_xf_load;
        xf_load && !wr_count |=> count_reg == $past(tag_low) && arm_reg == ARM_RUN;
    endproperty
    a_xf_load: assert property (p_xf_load) else $error("extended state load then count wrong");

    property p_xf_frozen;
        xf_mode && sel_reg == SEL_FROZEN && evt.cmd_valid && !sw_touch |=> $stable(count_reg);
    endproperty
    a_xf_frozen: assert property (p_xf_frozen) else $error("frozen counter moved on primitive");

    property p_wrap;
        sel_reg == SEL_FREE && count_reg == {CNT_W{1'b1}} && ev_thread && !sw_touch
            |=> count_reg == RST_COUNT;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap");

    property p_read_count;
        bus.rd && bus.addr == OFF_COUNT |=> rd_data_reg == {8'h00, $past(count_reg)};
    endproperty
    a_read_count: assert property (p_read_count) else $error("count read mismatch");

    property p_xf_run;
        xf_mode && sel_reg == SEL_ONCE && arm_reg == ARM_RUN && evt.cmd_valid && !sw_touch
            |=> count_reg == CNT_W'($past(count_reg) + 24'h000001);
    endproperty
    a_xf_run: assert property (p_xf_run) else $error("loaded counter missed primitive");

    property p_once_run_gen;
        gen_mode && sel_reg == SEL_ONCE && arm_reg == ARM_RUN && evt.cmd_valid && !sw_touch
            |=> count_reg == CNT_W'($past(count_reg) + 24'h000001);
    endproperty
    a_once_run_gen: assert property (p_once_run_gen) else $error("loaded counter missed command");

    property p_once_run_dec;
        dec_mode && sel_reg == SEL_ONCE && arm_reg == ARM_RUN && evt.mb_valid && !sw_touch
            |=> count_reg == CNT_W'($past(count_reg) + 24'h000001);
    endproperty
    a_once_run_dec: assert property (p_once_run_dec) else $error("loaded counter missed macroblock");

    // decode mode counts generated threads only, never the command itself
    property p_dec_cmd_ignored;
        dec_mode && evt.cmd_valid && !evt.mb_valid && !sw_touch |=> $stable(count_reg);
    endproperty
    a_dec_cmd_ignored: assert property (p_dec_cmd_ignored) else $error("decode mode counted a command");

    property p_gen_mb_ignored;
        gen_mode && evt.mb_valid && !evt.cmd_valid && !sw_touch
            |=> $stable(count_reg);
    endproperty
    a_gen_mb_ignored: assert property (p_gen_mb_ignored) else $error("general mode counted a macroblock");

    property p_idle_pulse;
        !evt.cmd_valid && !evt.mb_valid |=> !thread_pulse_reg;
    endproperty
    a_idle_pulse: assert property (p_idle_pulse) else $error("thread signalled without work");

    property p_rearm;
        wr_ctrl && wsel == SEL_ONCE && !rtdc_is_xform(wmode)
            |=> arm_reg == ARM_WAIT;
    endproperty
    a_rearm: assert property (p_rearm) else $error("state change did not arm the load");

    property p_restore;
        wr_count |=> count_reg == $past(bus.wdata[CNT_W-1:0]);
    endproperty
    a_restore: assert property (p_restore) else $error("count restore not taken");

    property p_read_idle;
        !bus.rd |=> rd_data_reg == RD_ZERO;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data not zero when idle");

    property p_read_status;
        bus.rd && bus.addr == OFF_STATUS |=> rd_data_reg == {29'h0000000, 3'($past(arm_reg))};
    endproperty
    a_read_status: assert property (p_read_status) else $error("status read mismatch");

    property p_read_tag;
        bus.rd && bus.addr == OFF_TAG |=> rd_data_reg == $past(tag_reg);
    endproperty
    a_read_tag: assert property (p_read_tag) else $error("tag read mismatch");

    property p_read_ctrl;
        bus.rd && bus.addr == OFF_CTRL |=> rd_data_reg[CTRL_SEL_LSB +: CTRL_SEL_W] == $past(sel_reg)
            && rd_data_reg[CTRL_MODE_LSB +: CTRL_MODE_W] == $past(mode_reg);
    endproperty
    a_read_ctrl: assert property (p_read_ctrl) else $error("control read mismatch");

    c_once_loaded: cover property (arm_reg == ARM_WAIT ##1 arm_reg == ARM_RUN);
    c_wrap: cover property (count_reg == {CNT_W{1'b1}} ##1 count_reg == RST_COUNT);
    c_dec_burst: cover property (dec_mode && evt.mb_valid ##1 evt.mb_valid ##1 evt.mb_valid);
    c_xf_load: cover property (xf_load);
    c_restore: cover property (wr_count);

endmodule : rtdc_counter
`default_nettype wire

// ### rtl/rtdc_next.sv
// next-value logic of the debug counter for one work event
`timescale 1ns/1ps
`default_nettype none
module rtdc_next (
    input wire logic [1:0] sel,
    input wire logic [2:0] mode,
    input wire rtdc_pkg::rtdc_arm_t arm,
    input wire rtdc_pkg::rtdc_evt_t evt,
    input wire logic [rtdc_pkg::CNT_W-1:0] count,
    output logic [rtdc_pkg::CNT_W-1:0] count_next,
    output logic loaded,
    output logic thread_event
);
    import rtdc_pkg::*;

    wire is_gen = rtdc_is_general(mode);
    wire is_dec = rtdc_is_decode(mode);
    wire is_xf = rtdc_is_xform(mode);
    // decode mode counts generated macroblock threads, general and transform modes count commands
    wire ev = is_dec ? evt.mb_valid : ((is_gen || is_xf) && evt.cmd_valid);
    wire [CNT_W-1:0] inc_val = count + 24'h000001;
    wire [CNT_W-1:0] tag_val = evt.tag[CNT_W-1:0];

    assign thread_event = ev;

    always_comb begin
        count_next = count;
        loaded = 1'b0;
        if (ev) begin
            case (sel)
                SEL_FREE: begin
                    count_next = inc_val;
                end
                SEL_FROZEN: begin
                    count_next = count;
                end
                SEL_ONCE: begin
                    if (arm == ARM_WAIT) begin
                        // decode mode waits for the first macroblock of a slice
                        if (!is_dec || evt.mb_first) begin
                            count_next = tag_val;
                            loaded = 1'b1;
                        end
                    end else if (arm == ARM_RUN) begin
                        count_next = inc_val;
                    end
                end
                default: begin
                    // reserved outside general modes: hold
                    if (is_gen) begin
                        count_next = tag_val;
                    end
                end
            endcase
        end
    end

endmodule : rtdc_next
`default_nettype wire

// ### rtl/rtdc_pkg.sv
// package: constants, types and mode decoding for the root thread debug counter
package rtdc_pkg;

    localparam int CNT_W = 24;
    localparam int TAG_W = 32;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_TAG = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0C;

    // control register field positions
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_SEL_W = 2;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_MODE_W = 3;

    // count-select codes
    localparam logic [1:0] SEL_FREE = 2'h0;
    localparam logic [1:0] SEL_FROZEN = 2'h1;
    localparam logic [1:0] SEL_ONCE = 2'h2;
    localparam logic [1:0] SEL_ALWAYS = 2'h3;

    // front end operating mode codes
    localparam logic [2:0] MODE_GENERAL = 3'h0;
    localparam logic [2:0] MODE_SLICE_FED = 3'h1;
    localparam logic [2:0] MODE_BITSTREAM_DECODE = 3'h2;
    localparam logic [2:0] MODE_H264_TRANSFORM = 3'h3;
    localparam logic [2:0] MODE_H264_MOTION_COMP = 3'h4;
    localparam logic [2:0] MODE_VC_INVERSE_TRANSFORM = 3'h5;

    // reset values
    localparam logic [CNT_W-1:0] RST_COUNT = 24'h000000;
    localparam logic [1:0] RST_SEL = SEL_FREE;
    localparam logic [2:0] RST_MODE = MODE_GENERAL;
    localparam logic [TAG_W-1:0] RST_TAG = 32'h00000000;
    localparam logic [DATA_W-1:0] RD_ZERO = 32'h00000000;

    typedef enum logic [2:0] {
        ARM_IDLE = 3'b001,
        ARM_WAIT = 3'b010,
        ARM_RUN = 3'b100
    } rtdc_arm_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } rtdc_bus_t;

    // work arriving from the command stream or made by the decode hardware
    typedef struct packed {
        logic cmd_valid;
        logic mb_valid;
        logic mb_first;
        logic [TAG_W-1:0] tag;
    } rtdc_evt_t;

    function automatic logic rtdc_is_general(input logic [2:0] mode);
        return (mode == MODE_GENERAL) || (mode == MODE_SLICE_FED);
    endfunction : rtdc_is_general

    function automatic logic rtdc_is_decode(input logic [2:0] mode);
        return mode == MODE_BITSTREAM_DECODE;
    endfunction : rtdc_is_decode

    function automatic logic rtdc_is_xform(input logic [2:0] mode);
        return (mode == MODE_H264_TRANSFORM) || (mode == MODE_H264_MOTION_COMP)
            || (mode == MODE_VC_INVERSE_TRANSFORM);
    endfunction : rtdc_is_xform

endpackage : rtdc_pkg

// ### testbench/rtdc_counter_tb.sv
// self-checking bench for the root thread debug counter
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module rtdc_counter_tb;
    import rtdc_pkg::*;
    logic core_clk;
    logic rst_n;
    rtdc_bus_t bus;
    rtdc_evt_t evt;
    logic [DATA_W-1:0] rd_data;
    logic [CNT_W-1:0] dbg_count;
    logic thread_pulse;
    logic [CNT_W-1:0] thread_count;
    logic [15:0] taken;
    logic [CNT_W-1:0] last_id;
    int err_total = 0;
    int compares = 0;

    rtdc_counter #(.SAVE_RESTORE(1'b1)) u_rtdc_counter (.core_clk(core_clk), .rst_n(rst_n), .bus(bus), .evt(evt),
        .rd_data(rd_data), .dbg_count(dbg_count), .thread_pulse(thread_pulse), .thread_count(thread_count));
    rtdc_spawner_model u_rtdc_spawner_model (.core_clk(core_clk), .rst_n(rst_n), .thread_pulse(thread_pulse),
        .thread_count(thread_count), .taken(taken), .last_id(last_id));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic void chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endfunction : chk

    function automatic logic [31:0] ctl(input logic [1:0] s, input logic [2:0] m);
        return {25'h0, m, 2'b00, s};
    endfunction : ctl

    task automatic step(input rtdc_bus_t b, input rtdc_evt_t e);
        @(posedge core_clk);
        bus <= b;
        evt <= e;
    endtask : step

    // one idle edge lets the last request land before looking
    task automatic settle();
        step('0, '0);
        #1;
    endtask : settle

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        step('{1'b1, 1'b0, a, d}, '0);
    endtask : wr

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        step('{1'b0, 1'b1, a, RD_ZERO}, '0);
        settle();
        `CHK(rd_data, e);
    endtask : rd_chk

    task automatic cmd(input logic [TAG_W-1:0] t);
        step('0, '{1'b1, 1'b0, 1'b0, t});
    endtask : cmd

    task automatic mb(input logic f, input logic [TAG_W-1:0] t);
        step('0, '{1'b0, 1'b1, f, t});
    endtask : mb

    task automatic do_reset();
        @(posedge core_clk);
        rst_n <= 1'b0;
        bus <= '0;
        evt <= '0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        `CHK(dbg_count, 0);
        rd_chk(OFF_STATUS, 32'h00000001);
        rd_chk(OFF_COUNT, 32'h00000000);
        rd_chk(8'h10, 32'h00000000);
        $display("reset test done");
    endtask : t_reset

    task automatic t_free();
        wr(OFF_CTRL, ctl(SEL_FREE, MODE_GENERAL));
        cmd(32'h00000009);
        settle();
        `CHK(thread_pulse, 1);
        `CHK(thread_count, 1);
        cmd(32'h0);
        cmd(32'h0);
        mb(1'b1, 32'h0);
        settle();
        `CHK(dbg_count, 3);
        wr(OFF_CTRL, ctl(SEL_FREE, MODE_SLICE_FED));
        cmd(32'h0);
        settle();
        `CHK(dbg_count, 4);
        // the spawner takes the pulse one edge after it appears
        settle();
        `CHK(taken, 4);
        `CHK(last_id, 4);
        $display("free running test done");
    endtask : t_free

    // a context not under debug keeps the counter frozen
    task automatic t_frozen();
        wr(OFF_CTRL, ctl(SEL_FROZEN, MODE_GENERAL));
        cmd(32'h0);
        cmd(32'h0);
        settle();
        `CHK(dbg_count, 4);
        wr(OFF_CTRL, ctl(SEL_FROZEN, MODE_BITSTREAM_DECODE));
        mb(1'b1, 32'h55);
        mb(1'b0, 32'h55);
        settle();
        `CHK(dbg_count, 4);
        wr(OFF_CTRL, ctl(SEL_FROZEN, MODE_H264_TRANSFORM));
        cmd(32'h0);
        settle();
        `CHK(dbg_count, 4);
        $display("frozen test done");
    endtask : t_frozen

    task automatic t_load();
        wr(OFF_CTRL, ctl(SEL_ONCE, MODE_GENERAL));
        cmd(32'hAB123456);
        settle();
        `CHK(dbg_count, 24'h123456);
        cmd(32'h00000077);
        settle();
        `CHK(dbg_count, 24'h123457);
        rd_chk(OFF_COUNT, 32'h00123457);
        wr(OFF_CTRL, ctl(SEL_ALWAYS, MODE_SLICE_FED));
        cmd(32'h00000077);
        cmd(32'h00000010);
        settle();
        `CHK(dbg_count, 24'h000010);
        $display("load test done");
    endtask : t_load

    // select 11 is never set in decode or transform modes
    task automatic t_decode();
        wr(OFF_CTRL, ctl(SEL_FREE, MODE_BITSTREAM_DECODE));
        mb(1'b1, 32'h0);
        mb(1'b0, 32'h0);
        mb(1'b0, 32'h0);
        cmd(32'h00000005);
        settle();
        `CHK(dbg_count, 24'h000013);
        wr(OFF_CTRL, ctl(SEL_ONCE, MODE_BITSTREAM_DECODE));
        mb(1'b0, 32'h00000300);
        settle();
        `CHK(dbg_count, 24'h000013);
        rd_chk(OFF_STATUS, 32'h00000002);
        mb(1'b1, 32'h00000200);
        mb(1'b0, 32'h00000300);
        mb(1'b1, 32'h00000999);
        settle();
        `CHK(dbg_count, 24'h000202);
        $display("decode test done");
    endtask : t_decode

    task automatic t_xform();
        logic [2:0] md;
        for (int i = 0; i < 3; i++) begin
            md = MODE_H264_TRANSFORM + 3'(i);
            wr(OFF_TAG, 32'hFF000100 + 32'(i));
            wr(OFF_CTRL, ctl(SEL_ONCE, md));
            settle();
            `CHK(dbg_count, 24'h000100 + 24'(i));
            cmd(32'h0);
            settle();
            `CHK(dbg_count, 24'h000101 + 24'(i));
            wr(OFF_CTRL, ctl(SEL_FREE, md));
            cmd(32'h0);
            cmd(32'h0);
            settle();
            `CHK(dbg_count, 24'h000103 + 24'(i));
        end
        rd_chk(OFF_TAG, 32'hFF000102);
        rd_chk(OFF_CTRL, ctl(SEL_FREE, MODE_VC_INVERSE_TRANSFORM));
        // unused mode codes count nothing
        wr(OFF_CTRL, ctl(SEL_FREE, 3'h6));
        cmd(32'h0);
        mb(1'b1, 32'h0);
        settle();
        `CHK(dbg_count, 24'h000105);
        $display("transform modes test done");
    endtask : t_xform

    task automatic t_wrap();
        wr(OFF_CTRL, ctl(SEL_ONCE, MODE_GENERAL));
        cmd(32'h00FFFFFF);
        cmd(32'h00000001);
        settle();
        `CHK(dbg_count, 0);
        wr(OFF_COUNT, 32'h00000042);
        settle();
        `CHK(dbg_count, 24'h000042);
        do_reset();
        `CHK(dbg_count, 0);
        `CHK(thread_count, 0);
        rd_chk(OFF_STATUS, 32'h00000001);
        $display("wrap and reset test done");
    endtask : t_wrap

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (5000) @(posedge core_clk);
        err_total++;
        finish_test();
    end

    initial begin
        rst_n = 1'b0;
        bus = '0;
        evt = '0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        t_reset();
        t_free();
        t_frozen();
        t_load();
        t_decode();
        t_xform();
        t_wrap();
        finish_test();
    end
endmodule : rtdc_counter_tb
`undef CHK
`default_nettype wire

// ### testbench/rtdc_spawner_model.sv
// thread spawner stand-in: takes each root thread the counter hands over
`timescale 1ns/1ps
`default_nettype none
module rtdc_spawner_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic thread_pulse,
    input wire logic [rtdc_pkg::CNT_W-1:0] thread_count,
    output logic [15:0] taken,
    output logic [rtdc_pkg::CNT_W-1:0] last_id
);
    import rtdc_pkg::*;
    // accepts at once: this path carries no back pressure
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            taken <= 16'h0000;
            last_id <= RST_COUNT;
        end else if (thread_pulse) begin
            taken <= taken + 16'h0001;
            last_id <= thread_count;
        end
    end
endmodule : rtdc_spawner_model
`default_nettype wire
